// ---- src/sleep_ctrl_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the sleep and reset block.
`ifndef SLEEP_CTRL_REGS_SVH
`define SLEEP_CTRL_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_POWER_SLEEP_CONTROL 8'h35
`define REG_PERIPHERAL_CLOCK_GATE 8'h36

// ****************************************
// Field positions
// ****************************************
`define PSC_BROWNOUT_OFF_IN_SLEEP 7
`define PSC_GLOBAL_PULLUP_OFF 6
`define PSC_SLEEP_ARM 5
`define PSC_SLEEP_MODE_HI 4
`define PSC_SLEEP_MODE_LO 3
`define PSC_BROWNOUT_OFF_UNLOCK 2
`define PSC_EXT_INT_SENSE_HI 1
`define PSC_EXT_INT_SENSE_LO 0
`define PCG_SECOND_TIMER 3
`define PCG_FIRST_TIMER 2
`define PCG_SERIAL_UNIT 1
`define PCG_CONVERTER 0

// ****************************************
// Reset values and timing counts
// ****************************************
`define PSC_RESET 8'h00
`define PCG_RESET 8'h00
`define PCG_WRITE_MASK 8'h0f
`define PSC_WRITE_MASK 8'h7b
`define UNLOCK_WINDOW_CYCLES 3'd4
`define BOD_OFF_DELAY_CYCLES 3'd3
`define BOD_OFF_HOLD_CYCLES 3'd3

`endif

// ---- src/sleep_ctrl_pkg.sv ----
// Types shared by the sleep, clock-gate and reset block.
package sleep_ctrl_pkg;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_QUIET = 2'b01,
    MODE_POWER_DOWN = 2'b10,
    MODE_RESERVED = 2'b11
  } sleep_mode_t;

  typedef enum logic [1:0] {
    BOD_IDLE = 2'b00,
    BOD_UNLOCKED = 2'b01,
    BOD_PENDING = 2'b10,
    BOD_ACTIVE = 2'b11
  } bod_state_t;

endpackage

// ---- src/sleep_clockgate_reset_ctrl.sv ----
// Sleep control, peripheral clock gating and reset stretching of a small microcontroller.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "sleep_ctrl_regs.svh"

module sleep_clockgate_reset_ctrl
  import sleep_ctrl_pkg::*;
#(
  parameter bit HAS_SW_BOD_DISABLE = 1'b1,
  parameter int TIMEOUT_WIDTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic sleep_instr_i,
  input wire logic wake_i,
  input wire logic power_ok_i,
  input wire logic ext_reset_n_i,
  input wire logic ext_reset_en_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_enable_i,
  input wire logic brownout_low_i,
  input wire logic brownout_fuse_en_i,
  input wire logic [TIMEOUT_WIDTH-1:0] timeout_cycles_i,
  input wire logic comparator_bandgap_select_i,
  input wire logic converter_enable_i,
  output logic cpu_clk_en_o,
  output logic io_clk_en_o,
  output logic converter_clk_en_o,
  output logic osc_en_o,
  output logic sleeping_o,
  output logic brownout_detector_off_o,
  output logic input_buffer_en_o,
  output logic watchdog_run_o,
  output logic second_timer_clk_en_o,
  output logic first_timer_clk_en_o,
  output logic serial_unit_clk_en_o,
  output logic converter_gate_en_o,
  output logic comparator_usable_o,
  output logic bandgap_en_o,
  output logic global_pullup_off_o,
  output logic [1:0] ext_int_sense_o,
  output logic internal_reset_o,
  output logic port_reset_o
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Refused at elaboration, so a bad width never reaches a netlist.
  if (TIMEOUT_WIDTH < 1 || TIMEOUT_WIDTH > 24) begin : g_width_check
    $error("TIMEOUT_WIDTH must lie between 1 and 24.");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] psc;
    logic [7:0] pcg;
    bod_state_t brownout_detector;
    logic [2:0] bod_cnt;
    logic sleeping;
    sleep_mode_t mode;
    logic bod_off;
    logic wd_q;
    logic stretching;
    logic [TIMEOUT_WIDTH-1:0] delay_cnt;
    logic internal_reset;
    logic [7:0] rdata;
    logic cpu_clk_en;
    logic io_clk_en;
    logic conv_clk_en;
    logic osc_en;
    logic in_buf_en;
    logic [3:0] gate_en;
    logic comp_usable;
    logic bandgap;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic async_source;
  logic por_or_pin_n;

  // Sources that need no clock: power loss, enabled pin low, enabled brown-out.
  assign async_source = !power_ok_i || (ext_reset_en_i && !ext_reset_n_i) ||
                        (brownout_fuse_en_i && brownout_low_i);

  // Port reset is purely combinational from resetn_i and the asynchronous sources.
  assign por_or_pin_n = resetn_i && !async_source;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic psc_wr;
    logic pcg_wr;
    logic [7:0] wd;
    logic any_src;
    logic sleep_ok;
    sleep_mode_t sel;
    psc_wr = reg_wr_i && (reg_addr_i == `REG_POWER_SLEEP_CONTROL);
    pcg_wr = reg_wr_i && (reg_addr_i == `REG_PERIPHERAL_CLOCK_GATE);
    wd = reg_wdata_i;
    s_d = s_q;

    // Plain read/write bits; brown-out bits are handled by the unlock machine.
    if (psc_wr) begin
      s_d.psc = (s_q.psc & ~`PSC_WRITE_MASK) | (wd & `PSC_WRITE_MASK);
      s_d.psc[`PSC_BROWNOUT_OFF_UNLOCK] = 1'b0;
    end
    if (pcg_wr) begin
      s_d.pcg = wd & `PCG_WRITE_MASK;
    end

    // Timed unlock of the brown-out-off bit.
    case (s_q.brownout_detector)
      BOD_IDLE: begin
        s_d.bod_cnt = 3'd0;
      end
      BOD_UNLOCKED: begin
        s_d.bod_cnt = s_q.bod_cnt + 3'd1;
        if (s_q.bod_cnt + 3'd1 >= `UNLOCK_WINDOW_CYCLES) begin
          s_d.brownout_detector = BOD_IDLE;
        end
      end
      BOD_PENDING: begin
        s_d.bod_cnt = s_q.bod_cnt + 3'd1;
        if (s_q.bod_cnt + 3'd1 >= `BOD_OFF_DELAY_CYCLES) begin
          s_d.brownout_detector = BOD_ACTIVE;
          s_d.bod_cnt = 3'd0;
        end
      end
      BOD_ACTIVE: begin
        s_d.bod_cnt = s_q.bod_cnt + 3'd1;
        if (s_q.bod_cnt + 3'd1 >= `BOD_OFF_HOLD_CYCLES) begin
          s_d.brownout_detector = BOD_IDLE;
        end
      end
      default: begin
        s_d.brownout_detector = BOD_IDLE;
      end
    endcase
    if (psc_wr && HAS_SW_BOD_DISABLE) begin
      if (wd[`PSC_BROWNOUT_OFF_IN_SLEEP] && wd[`PSC_BROWNOUT_OFF_UNLOCK]) begin
        s_d.brownout_detector = BOD_UNLOCKED;
        s_d.bod_cnt = 3'd0;
      end else if (s_q.brownout_detector == BOD_UNLOCKED && wd[`PSC_BROWNOUT_OFF_IN_SLEEP]) begin
        s_d.brownout_detector = BOD_PENDING;
        s_d.bod_cnt = 3'd0;
      end else if (s_q.brownout_detector == BOD_UNLOCKED) begin
        s_d.brownout_detector = BOD_IDLE;
      end
    end
    // Software view of both bits; zero when the feature is absent.
    s_d.psc[`PSC_BROWNOUT_OFF_IN_SLEEP] = HAS_SW_BOD_DISABLE &&
      (s_d.brownout_detector == BOD_PENDING || s_d.brownout_detector == BOD_ACTIVE);
    s_d.psc[`PSC_BROWNOUT_OFF_UNLOCK] = HAS_SW_BOD_DISABLE && (s_d.brownout_detector == BOD_UNLOCKED);

    // Sleep entry and wake-up.
    sel = sleep_mode_t'(s_q.psc[`PSC_SLEEP_MODE_HI:`PSC_SLEEP_MODE_LO]);
    sleep_ok = sleep_instr_i && s_q.psc[`PSC_SLEEP_ARM] && sel != MODE_RESERVED;
    if (s_q.sleeping && wake_i) begin
      s_d.sleeping = 1'b0;
      s_d.bod_off = 1'b0;
    end else if (!s_q.sleeping && sleep_ok) begin
      s_d.sleeping = 1'b1;
      s_d.mode = sel;
      s_d.bod_off = (s_q.brownout_detector == BOD_ACTIVE);
    end

    // Clock enables by mode; watchdog is never stopped by sleep.
    s_d.cpu_clk_en = !s_d.sleeping;
    s_d.io_clk_en = !s_d.sleeping || s_d.mode == MODE_IDLE;
    s_d.conv_clk_en = !s_d.sleeping || s_d.mode != MODE_POWER_DOWN;
    s_d.osc_en = !s_d.sleeping || s_d.mode != MODE_POWER_DOWN;
    // Input buffers stay on only when one of those clocks runs; wake pins bypass this.
    s_d.in_buf_en = s_d.io_clk_en || s_d.conv_clk_en;

    // Peripheral gates freeze clocks; the peripheral keeps its state.
    for (int i = 0; i < 4; i++) begin
      s_d.gate_en[i] = !s_d.pcg[i];
    end
    s_d.comp_usable = !s_d.pcg[`PCG_CONVERTER];
    s_d.bandgap = brownout_fuse_en_i || comparator_bandgap_select_i ||
                  converter_enable_i;

    // Reset stretch: watchdog pulse starts the delay on its falling edge.
    s_d.wd_q = watchdog_timeout_i && watchdog_enable_i;
    any_src = s_d.wd_q;
    if (any_src) begin
      s_d.stretching = 1'b1;
      s_d.internal_reset = 1'b1;
      s_d.delay_cnt = '0;
    end else if (s_q.stretching) begin
      if (s_q.delay_cnt >= timeout_cycles_i) begin
        s_d.stretching = 1'b0;
        s_d.internal_reset = 1'b0;
      end else begin
        s_d.delay_cnt = s_q.delay_cnt + 1'b1;
      end
    end

    // Read data stand in the cycle after the strobe.
    s_d.rdata = 8'h00;
    if (reg_rd_i && reg_addr_i == `REG_POWER_SLEEP_CONTROL) begin
      s_d.rdata = s_q.psc;
    end else if (reg_rd_i && reg_addr_i == `REG_PERIPHERAL_CLOCK_GATE) begin
      s_d.rdata = s_q.pcg & `PCG_WRITE_MASK;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Any asynchronous source resets all state at once, so every register takes its
  // initial value without a clock and the stretch begins from the release.
  always_ff @(posedge clk_sys_i or negedge por_or_pin_n) begin
    if (!por_or_pin_n) begin
      s_q <= '0;
      s_q.psc <= `PSC_RESET;
      s_q.pcg <= `PCG_RESET;
      s_q.internal_reset <= 1'b1;
      s_q.stretching <= 1'b1;
      s_q.cpu_clk_en <= 1'b1;
      s_q.io_clk_en <= 1'b1;
      s_q.conv_clk_en <= 1'b1;
      s_q.osc_en <= 1'b1;
      s_q.in_buf_en <= 1'b1;
      s_q.gate_en <= 4'hf;
      s_q.comp_usable <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata_o = s_q.rdata;
  assign cpu_clk_en_o = s_q.cpu_clk_en;
  assign io_clk_en_o = s_q.io_clk_en;
  assign converter_clk_en_o = s_q.conv_clk_en;
  assign osc_en_o = s_q.osc_en;
  assign sleeping_o = s_q.sleeping;
  assign brownout_detector_off_o = s_q.bod_off;
  assign input_buffer_en_o = s_q.in_buf_en;
  assign watchdog_run_o = 1'b1; // Sleep never stops the watchdog.
  assign second_timer_clk_en_o = s_q.gate_en[`PCG_SECOND_TIMER];
  assign first_timer_clk_en_o = s_q.gate_en[`PCG_FIRST_TIMER];
  assign serial_unit_clk_en_o = s_q.gate_en[`PCG_SERIAL_UNIT];
  assign converter_gate_en_o = s_q.gate_en[`PCG_CONVERTER];
  assign comparator_usable_o = s_q.comp_usable;
  assign bandgap_en_o = s_q.bandgap;
  assign global_pullup_off_o = s_q.psc[`PSC_GLOBAL_PULLUP_OFF];
  assign ext_int_sense_o = s_q.psc[`PSC_EXT_INT_SENSE_HI:`PSC_EXT_INT_SENSE_LO];
  assign internal_reset_o = s_q.internal_reset;
  // Port reset is the only combinational output: it must act with no clock.
  assign port_reset_o = !por_or_pin_n;

endmodule

// ---- dv/sleep_ctrl_chk_sva.sv ----
// Port assertions of the sleep, clock-gate and reset block.
`timescale 1ns/1ps
module sleep_ctrl_chk (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic power_ok_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_enable_i,
  input wire logic brownout_fuse_en_i,
  input wire logic comparator_bandgap_select_i,
  input wire logic converter_enable_i,
  input wire logic cpu_clk_en_o,
  input wire logic sleeping_o,
  input wire logic brownout_detector_off_o,
  input wire logic watchdog_run_o,
  input wire logic second_timer_clk_en_o,
  input wire logic comparator_usable_o,
  input wire logic bandgap_en_o,
  input wire logic internal_reset_o,
  input wire logic port_reset_o
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // A following gate write would mask the first, so only lone writes are judged.
  property p_gate_timer;
    reg_wr_i && reg_addr_i == 8'h36 ##1 !(reg_wr_i && reg_addr_i == 8'h36)
      |=> second_timer_clk_en_o == !$past(reg_wdata_i[3], 2);
  endproperty
  a_gate_timer: assert property (p_gate_timer) else $error("timer gate wrong");
  property p_gate_cmp;
    reg_wr_i && reg_addr_i == 8'h36 ##1 !(reg_wr_i && reg_addr_i == 8'h36)
      |=> comparator_usable_o == !$past(reg_wdata_i[0], 2);
  endproperty
  a_gate_cmp: assert property (p_gate_cmp) else $error("comparator gate wrong");
  property p_gate_rsvd;
    reg_rd_i && reg_addr_i == 8'h36 |=> reg_rdata_o[7:4] == 4'h0;
  endproperty
  a_gate_rsvd: assert property (p_gate_rsvd) else $error("gate high bits set");
  // A source reset clears the reference register, so quiet cycles only.
  property p_refon;
    !port_reset_o && $past(!port_reset_o) |-> bandgap_en_o ==
      $past(brownout_fuse_en_i | comparator_bandgap_select_i | converter_enable_i);
  endproperty
  a_refon: assert property (p_refon) else $error("reference enable wrong");
  // The run uses a stretch of four, so reset holds five cycles at least.
  property p_wdog;
    watchdog_timeout_i && watchdog_enable_i |=> internal_reset_o [*5];
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset short");
  property p_por;
    !power_ok_i |-> port_reset_o && internal_reset_o;
  endproperty
  a_por: assert property (p_por) else $error("power loss not reset");
  property p_wrun;
    watchdog_run_o;
  endproperty
  a_wrun: assert property (p_wrun) else $error("watchdog stopped");
  property p_cpu;
    $rose(sleeping_o) |=> !cpu_clk_en_o;
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu clock runs in sleep");
  property p_bodoff;
    brownout_detector_off_o |-> sleeping_o || $past(sleeping_o);
  endproperty
  a_bodoff: assert property (p_bodoff) else $error("detector off awake");
endmodule

bind sleep_clockgate_reset_ctrl sleep_ctrl_chk u_chk (.*);

// ---- dv/tb_sleep_clockgate_reset_ctrl.sv ----
// Self-checking testbench of the sleep, clock-gate and reset block.
`timescale 1ns/1ps
module tb_sleep_clockgate_reset_ctrl;
  typedef struct {logic [7:0] a, w, r; logic [3:0] g;} row_t;
  logic clk_sys_i, resetn_i, reg_wr_i, reg_rd_i, sleep_instr_i, wake_i, power_ok_i;
  logic ext_reset_n_i, ext_reset_en_i, watchdog_timeout_i, watchdog_enable_i, brownout_low_i;
  logic brownout_fuse_en_i, comparator_bandgap_select_i, converter_enable_i;
  logic cpu_clk_en_o, io_clk_en_o, converter_clk_en_o, osc_en_o, sleeping_o;
  logic brownout_detector_off_o, input_buffer_en_o, watchdog_run_o, second_timer_clk_en_o;
  logic first_timer_clk_en_o, serial_unit_clk_en_o, converter_gate_en_o, comparator_usable_o;
  logic bandgap_en_o, global_pullup_off_o, internal_reset_o, port_reset_o;
  logic [1:0] ext_int_sense_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [15:0] timeout_cycles_i;
  int fail_count = 0;
  int num_checks = 0;
  // Gate rows: refused high bits, gates 0 and 2 then gates 1 and 3, an unmapped place, refused lock bits.
  row_t rows[6] = '{'{8'h36, 8'hff, 8'h0f, 4'h0}, '{8'h36, 8'h05, 8'h05, 4'ha},
    '{8'h36, 8'h0a, 8'h0a, 4'h5}, '{8'h40, 8'hff, 8'h00, 4'h5},
    '{8'h35, 8'h80, 8'h00, 4'h5}, '{8'h35, 8'h04, 8'h00, 4'h5}};

  sleep_clockgate_reset_ctrl #(.TIMEOUT_WIDTH(16)) DUT (.*);

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task chk(logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task cyc(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task wr(logic [7:0] a, logic [7:0] w);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= w;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task rd(logic [7:0] a);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task pul(logic s, logic w);
    @(posedge clk_sys_i);
    sleep_instr_i <= s;
    wake_i <= w;
    @(posedge clk_sys_i);
    sleep_instr_i <= 1'b0;
    wake_i <= 1'b0;
    cyc(2);
  endtask
  // Bounded count of the stretched reset; running out is a mismatch.
  task hold();
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (internal_reset_o === 1'b1 && n < 50);
    chk(8'(n), 8'd5);
    if (n >= 50) stop_test();
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {resetn_i, reg_wr_i, reg_rd_i, sleep_instr_i, wake_i, watchdog_timeout_i} = '0;
    {ext_reset_en_i, watchdog_enable_i, brownout_low_i, brownout_fuse_en_i} = '0;
    {comparator_bandgap_select_i, converter_enable_i, reg_addr_i, reg_wdata_i} = '0;
    {power_ok_i, ext_reset_n_i} = 2'b11;
    timeout_cycles_i = 16'd4;
    cyc(5);
    chk(internal_reset_o, 1);
    chk(port_reset_o, 1);
    resetn_i <= 1'b1;
    hold();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(d, rows[i].r);
      cyc(1);
      chk({second_timer_clk_en_o, first_timer_clk_en_o, serial_unit_clk_en_o,
        converter_gate_en_o}, rows[i].g);
      chk(comparator_usable_o, rows[i].g[0]);
    end
    $display("gate rows done");
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    cyc(2);
    resetn_i <= 1'b1;
    hold();
    rd(8'h36);
    chk(d, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(8'h35, 8'h20 | 8'(m << 3));
      pul(1'b1, 1'b0);
      chk(sleeping_o, m != 3);
      chk(cpu_clk_en_o, m == 3);
      chk(io_clk_en_o, m == 0 || m == 3);
      chk(osc_en_o, m != 2);
      chk(input_buffer_en_o, m != 2);
      pul(1'b0, 1'b1);
      wr(8'h35, 8'(m << 3));
      chk(cpu_clk_en_o, 1);
    end
    wr(8'h35, 8'h10);
    pul(1'b1, 1'b0);
    chk(sleeping_o, 0);
    $display("sleep modes done");
    wr(8'h35, 8'h34);
    wr(8'h35, 8'hb4);
    wr(8'h35, 8'hb0);
    rd(8'h35);
    chk(d, 8'hb0);
    pul(1'b1, 1'b0);
    chk(brownout_detector_off_o, 1);
    pul(1'b0, 1'b1);
    chk(brownout_detector_off_o, 0);
    rd(8'h35);
    chk(d, 8'h30);
    wr(8'h35, 8'h84);
    cyc(6);
    wr(8'h35, 8'h80);
    rd(8'h35);
    chk(d, 8'h00);
    $display("lock sequence done");
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys_i);
      {brownout_fuse_en_i, comparator_bandgap_select_i, converter_enable_i} <= 3'(k);
      // Let the reference settle before its enable is judged.
      cyc(2);
      chk(bandgap_en_o, k != 0);
    end
    // Sources 0..3 are power, pin, watchdog, brown-out; the upper half enables pin, watchdog and brown-out.
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys_i);
      {ext_reset_en_i, watchdog_enable_i, brownout_fuse_en_i} <= {3{k > 3}};
      power_ok_i <= k % 4 != 0;
      ext_reset_n_i <= k % 4 != 1;
      watchdog_timeout_i <= k % 4 == 2;
      brownout_low_i <= k % 4 == 3;
      #1;
      if (k % 4 != 2) chk(port_reset_o, k > 3 || k == 0);
      @(posedge clk_sys_i);
      {power_ok_i, ext_reset_n_i, watchdog_timeout_i, brownout_low_i} <= 4'b1100;
      if (k > 3 || k == 0) hold();
      else begin
        cyc(2);
        chk(internal_reset_o, 0);
      end
    end
    $display("reset sources done");
    stop_test();
  end
endmodule
